// ===== lane_align.sv
`timescale 1ns/1ps
// word fifo, registered pointers and count
module stream_fifo #(
    parameter int WIDTH = 35,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_in,       // clock
    input  wire logic             rst_b_in,     // async reset
    input  wire logic             in_valid_in,  // push request
    output logic                  in_ready_out, // room left
    input  wire logic [WIDTH-1:0] in_data_in,   // push word
    output logic                  out_valid_out,// word held
    input  wire logic             out_ready_in, // pop request
    output logic [WIDTH-1:0]      out_data_out, // head word
    output logic [$clog2(DEPTH):0] count_out    // fill level
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem; // storage
        logic [AW-1:0]               wp;  // write pointer
        logic [AW-1:0]               rp;  // read pointer
        logic [AW:0]                 cnt; // words held
    } fifo_s;
    fifo_s q;
    fifo_s d;
    logic  push;
    logic  pop;

    // flags come from the registered count
    assign in_ready_out  = (q.cnt != FULL);
    assign out_valid_out = (q.cnt != '0);
    assign out_data_out  = q.mem[q.rp];
    assign count_out     = q.cnt;

    // pointer and count update
    always_comb
    begin
        d    = q;
        push = in_valid_in && in_ready_out;
        pop  = out_ready_in && out_valid_out;
        if (push)
        begin
            d.mem[q.wp] = in_data_in;
            d.wp        = q.wp + {{(AW-1){1'b0}}, 1'b1};
        end
        if (pop)
            d.rp = q.rp + {{(AW-1){1'b0}}, 1'b1};
        d.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    // state register
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            q <= '0;
        else
            q <= d;
    end
endmodule

`timescale 1ns/1ps
module lane_align_top
    import align_pkg::*;
(
    input  wire logic                          clk_in,        // pclk
    input  wire logic                          rst_b_in,      // async reset
    input  wire logic [11:0]                   reg_addr_in,   // reg address
    input  wire logic                          reg_wr_in,     // write strobe
    input  wire logic [7:0]                    reg_wdata_in,  // write data
    output logic [7:0]                         reg_rdata_out, // read data
    input  wire logic [align_pkg::DATA_W-1:0]  lane_data_in,  // four octets
    input  wire logic [align_pkg::LANE_W-1:0]  lane_id_in,    // logical lane
    input  wire logic                          lane_valid_in, // word valid
    output logic                               lane_ready_out,// room
    input  wire logic                          ilas_end_in,   // first data
    input  wire logic                          sysref_in,     // sysref pin
    input  wire logic [1:0]                    dac_phase_in,  // div4 phase
    output logic [align_pkg::DATA_W-1:0]       data_out,      // octets out
    output logic [align_pkg::LANE_W-1:0]       data_lane_out, // lane out
    output logic                               data_valid_out,// out valid
    input  wire logic                          data_ready_in, // sink ready
    output logic                               lmfc_rx_out,   // local mf
    output logic                               edge_tolerance_irq_out, // jitter
    output logic                               link_enable_out // link on
);
    import align_pkg::*;

    typedef struct packed {
        sync_state_e       st;          // sync machine
        logic [7:0]        inv;         // lane invert
        logic [7:0]        scr_cfg;     // scramble reg
        logic [7:0]        subclass;    // subclass reg
        logic [7:0]        jwin;        // window reg
        logic [7:0]        mode;        // mode reg
        logic [7:0]        link_ctrl;   // link reg
        logic [7:0]        mf_del;      // mf delay
        logic [7:0]        mf_var;      // mf variation
        logic [7:0]        hyst_a;      // hysteresis a
        logic [7:0]        hyst_b;      // hysteresis b
        logic              sref_meta;   // sync ff 1
        logic              sref_sync;   // sync ff 2
        logic              sref_prev;   // edge history
        logic [7:0]        lmfc_cnt;    // aligned mf phase
        logic [7:0]        ref_cnt;     // internal mf
        logic [7:0]        edge_cnt;    // sysref pulses
        logic [7:0]        edge_snap;   // latched count
        logic [15:0]       status_val;  // last error
        logic [15:0]       status_snap; // latched status
        logic [11:0]       phase_code;  // capture phase
        logic              irq;         // jitter flag
        logic [7:0]        latency;     // latency
        logic              lat_armed;   // data seen
        logic              rx_seen;     // mf edge seen
        logic              released;    // buffer open
        logic [7:0]        rel_cnt;     // release wait
        logic              s1_valid;    // stage valid
        logic [DATA_W-1:0] s1_data;     // stage data
        logic [LANE_W-1:0] s1_lane;     // stage lane
        logic [7:0][14:0]  hist;        // lane history
        logic              out_valid;   // out valid
        logic [DATA_W-1:0] out_data;    // out data
        logic [LANE_W-1:0] out_lane;    // out lane
        logic [7:0]        rdata;       // read data
        logic              in_ready;    // input room
        logic              lmfc_pulse;  // mf pulse
    } state_s;

    state_s q;
    state_s d;

    logic              sref_edge;  // sysref rise
    logic              ref_wrap;   // internal edge
    logic              align_edge; // alignment edge
    logic              do_align;   // adjust phase
    logic              jitter;     // outside window
    logic [7:0]        to_end;     // cycles to wrap
    logic [7:0]        err;        // phase error
    logic [7:0]        rx_cnt;     // local mf phase
    logic              link_en;    // link on
    logic [46:0]       chain;      // history+word
    logic [DATA_W-1:0] descr;      // descrambled
    logic              f_in_ready; // fifo room
    logic              f_out_valid;// fifo word
    logic              take;       // fifo pop
    logic [FIFO_W-1:0] f_out;      // fifo head
    logic [4:0]        f_count;    // fifo level
    logic              wr_mode;    // mode write

    // buffer in front of the release gate
    stream_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (clk_in),
        .rst_b_in      (rst_b_in),
        .in_valid_in   (q.s1_valid && link_en),
        .in_ready_out  (f_in_ready),
        .in_data_in    ({q.s1_lane, descr}),
        .out_valid_out (f_out_valid),
        .out_ready_in  (take),
        .out_data_out  (f_out),
        .count_out     (f_count)
    );

    // next state of the whole block
    always_comb
    begin
        d       = q;
        link_en = q.link_ctrl[LINK_EN_BIT];
        wr_mode = reg_wr_in && (reg_addr_in == OFS_MODE);
        d.sref_meta = sysref_in;
        d.sref_sync = q.sref_meta;
        d.sref_prev = q.sref_sync;
        sref_edge   = q.sref_sync && !q.sref_prev;
        ref_wrap  = (q.ref_cnt == MF_PCLKS - 8'h01);
        d.ref_cnt = ref_wrap ? 8'h00 : q.ref_cnt + 8'h01;
        if (q.subclass[7:SUBCLASS_LSB] == SUBCLASS_1)
            align_edge = sref_edge;
        else if (q.subclass[7:SUBCLASS_LSB] == SUBCLASS_0)
            align_edge = ref_wrap;
        else
            align_edge = 1'b0;
        to_end = MF_PCLKS - q.lmfc_cnt;
        err    = (q.lmfc_cnt <= to_end) ? q.lmfc_cnt : to_end;
        jitter   = align_edge && (err > {4'h0, q.jwin[5:2]});
        do_align = align_edge && (q.st == ST_ARMED || q.st == ST_CONT);
        if (do_align)
            d.lmfc_cnt = 8'h01;
        else if (q.lmfc_cnt == MF_PCLKS - 8'h01)
            d.lmfc_cnt = 8'h00;
        else
            d.lmfc_cnt = q.lmfc_cnt + 8'h01;
        if (align_edge)
            d.status_val = {6'h00, q.lmfc_cnt, 2'b00};
        if (sref_edge)
            d.phase_code = 12'(13'h0008 << (3 * dac_phase_in)) - 12'h001;
        // sync machine
        unique case (q.st)
            ST_ARMED: if (align_edge) d.st = ST_MON;
            ST_IDLE:  d.st = ST_IDLE;
            ST_MON:   d.st = ST_MON;
            ST_CONT:  d.st = ST_CONT;
        endcase
        if (wr_mode)
        begin
            d.mode = {6'h00, reg_wdata_in[1:0]};
            if (reg_wdata_in[1:0] == MODE_ONESHOT)
                d.st = ST_ARMED;
            else if (reg_wdata_in[1:0] == MODE_CONT)
                d.st = ST_CONT;
            else
                d.st = ST_IDLE;
        end
        if (reg_wr_in && reg_addr_in == OFS_PULSES)
            d.edge_cnt = sref_edge ? 8'h01 : 8'h00;
        else if (sref_edge)
            d.edge_cnt = q.edge_cnt + 8'h01;
        if (reg_wr_in && reg_addr_in == OFS_STAT_LO)
        begin
            d.status_snap = q.status_val;
            d.edge_snap   = q.edge_cnt;
        end
        if (reg_wr_in && reg_addr_in == OFS_IRQ && reg_wdata_in[IRQ_BIT])
            d.irq = 1'b0;
        if (jitter)
            d.irq = 1'b1;
        // plain register writes
        if (reg_wr_in)
        begin
            unique case (reg_addr_in)
                OFS_JWIN:     d.jwin      = {2'b00, reg_wdata_in[5:0]};
                OFS_LINK:     d.link_ctrl = reg_wdata_in;
                OFS_MF_DEL:   d.mf_del    = reg_wdata_in;
                OFS_MF_VAR:   d.mf_var    = reg_wdata_in;
                OFS_INVERT:   d.inv       = reg_wdata_in;
                OFS_SCR:      d.scr_cfg   = reg_wdata_in;
                OFS_SUBCLASS: d.subclass  = reg_wdata_in;
                OFS_HYST_A:   d.hyst_a    = reg_wdata_in;
                OFS_HYST_B:   d.hyst_b    = reg_wdata_in;
                default:      d.rdata     = q.rdata;
            endcase
        end
        if (q.lmfc_cnt >= q.mf_del)
            rx_cnt = q.lmfc_cnt - q.mf_del;
        else
            rx_cnt = q.lmfc_cnt + MF_PCLKS - q.mf_del;
        d.lmfc_pulse = (rx_cnt == 8'h00);
        if (link_en && ilas_end_in && !q.lat_armed)
        begin
            d.latency   = rx_cnt;
            d.lat_armed = 1'b1;
        end
        if (q.lat_armed && !q.rx_seen && rx_cnt == 8'h00)
        begin
            d.rx_seen = 1'b1;
            d.rel_cnt = q.mf_var;
        end
        if (q.rx_seen && !q.released)
        begin
            if (q.rel_cnt == 8'h00)
                d.released = 1'b1;
            else
                d.rel_cnt = q.rel_cnt - 8'h01;
        end
        // link off restarts latency and release
        if (!link_en)
        begin
            d.lat_armed = 1'b0;
            d.rx_seen   = 1'b0;
            d.released  = 1'b0;
        end
        d.s1_valid = lane_valid_in && q.in_ready;
        if (lane_valid_in && q.in_ready)
        begin
            d.s1_data = lane_data_in ^ {DATA_W{q.inv[lane_id_in]}};
            d.s1_lane = lane_id_in;
        end
        // taps 14 and 15 back, msb first
        chain = {q.hist[q.s1_lane], q.s1_data};
        for (int k = 0; k < DATA_W; k++)
            descr[k] = chain[k] ^ chain[k + 14] ^ chain[k + 15];
        if (!q.scr_cfg[SCR_BIT])
            descr = q.s1_data;
        if (q.s1_valid)
            d.hist[q.s1_lane] = q.s1_data[14:0];
        // output register, gated by release
        take = f_out_valid && q.released && (!q.out_valid || data_ready_in);
        if (take)
        begin
            d.out_valid = 1'b1;
            d.out_data  = f_out[DATA_W-1:0];
            d.out_lane  = f_out[FIFO_W-1:DATA_W];
        end
        else if (data_ready_in)
            d.out_valid = 1'b0;
        // ready leaves room for words in flight
        d.in_ready = (f_count < FIFO_ROOM) && f_in_ready;
        // read mux, answer next cycle
        unique case (reg_addr_in)
            OFS_STAT_LO:  d.rdata = q.status_snap[7:0];
            OFS_STAT_HI:  d.rdata = q.status_snap[15:8];
            OFS_PULSES:   d.rdata = q.edge_snap;
            OFS_PHASE_LO: d.rdata = q.phase_code[7:0];
            OFS_PHASE_HI: d.rdata = {4'h0, q.phase_code[11:8]};
            OFS_JWIN:     d.rdata = q.jwin;
            OFS_MODE:     d.rdata = q.mode;
            OFS_IRQ:      d.rdata = {7'h00, q.irq};
            OFS_HYST_A:   d.rdata = q.hyst_a;
            OFS_HYST_B:   d.rdata = q.hyst_b;
            OFS_LINK:     d.rdata = q.link_ctrl;
            OFS_LATENCY:  d.rdata = q.latency;
            OFS_MF_DEL:   d.rdata = q.mf_del;
            OFS_MF_VAR:   d.rdata = q.mf_var;
            OFS_INVERT:   d.rdata = q.inv;
            OFS_SCR:      d.rdata = q.scr_cfg;
            OFS_SUBCLASS: d.rdata = q.subclass;
            default:      d.rdata = 8'h00;
        endcase
    end

    // state register with reset values
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            q          <= '0;
            q.st       <= ST_IDLE;
            q.subclass <= RST_SUBCLASS;
            q.jwin     <= RST_JWIN;
        end
        else
            q <= d;
    end

    // outputs straight from flops
    assign reg_rdata_out          = q.rdata;
    assign lane_ready_out         = q.in_ready;
    assign data_out               = q.out_data;
    assign data_lane_out          = q.out_lane;
    assign data_valid_out         = q.out_valid;
    assign lmfc_rx_out            = q.lmfc_pulse;
    assign edge_tolerance_irq_out = q.irq;
    assign link_enable_out        = q.link_ctrl[LINK_EN_BIT];

    // checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);

    logic inv_now;
    assign inv_now = q.inv[lane_id_in];

    lane_invert_a: assert property (
        lane_valid_in && q.in_ready |=>
        q.s1_valid && q.s1_data == ($past(lane_data_in) ^ {DATA_W{$past(inv_now)}}))
        else $error("lane inversion wrong");
    descr_bypass_a: assert property (
        q.s1_valid && !q.scr_cfg[SCR_BIT] |-> descr == q.s1_data)
        else $error("bypass altered data");
    oneshot_once_a: assert property (
        q.st == ST_ARMED && align_edge && !wr_mode |=> q.st == ST_MON && q.lmfc_cnt == 8'h01)
        else $error("one-shot did not align");
    monitor_hold_a: assert property (
        q.st == ST_MON && align_edge && q.lmfc_cnt < 8'h0e |=> q.lmfc_cnt == $past(q.lmfc_cnt) + 8'h01)
        else $error("monitor moved phase");
    cont_realign_a: assert property (
        q.st == ST_CONT && align_edge && !wr_mode |=> q.lmfc_cnt == 8'h01 ##1 q.lmfc_cnt == 8'h02)
        else $error("continuous did not align");
    pulse_clear_a: assert property (
        reg_wr_in && reg_addr_in == OFS_PULSES && !sref_edge |=> q.edge_cnt == 8'h00)
        else $error("pulse count not cleared");
    jitter_set_a: assert property (
        align_edge && err > {4'h0, q.jwin[5:2]} |=> q.irq [*2])
        else $error("jitter flag missing");
    irq_sticky_a: assert property (
        q.irq && !(reg_wr_in && reg_addr_in == OFS_IRQ) |=> q.irq)
        else $error("jitter flag dropped");
    snap_latch_a: assert property (
        reg_wr_in && reg_addr_in == OFS_STAT_LO |=> q.status_snap == $past(q.status_val))
        else $error("status not latched");
    sysref_edge_a: assert property (
        sref_edge && !(reg_wr_in && reg_addr_in == OFS_PULSES) |=>
        q.edge_cnt == $past(q.edge_cnt) + 8'h01)
        else $error("sysref edge missed");

    oneshot_c: cover property (q.st == ST_ARMED ##[1:200] q.st == ST_MON);
    jitter_c: cover property ($rose(q.irq));
    release_c: cover property ($rose(q.released) ##[1:40] data_valid_out);
endmodule

// ===== align_pkg.sv
package align_pkg;
    // register offsets
    localparam logic [11:0] OFS_STAT_LO  = 12'h034;
    localparam logic [11:0] OFS_STAT_HI  = 12'h035;
    localparam logic [11:0] OFS_PULSES   = 12'h036;
    localparam logic [11:0] OFS_PHASE_LO = 12'h037;
    localparam logic [11:0] OFS_PHASE_HI = 12'h038;
    localparam logic [11:0] OFS_JWIN     = 12'h039;
    localparam logic [11:0] OFS_MODE     = 12'h03a;
    localparam logic [11:0] OFS_IRQ      = 12'h03b;
    localparam logic [11:0] OFS_HYST_A   = 12'h088;
    localparam logic [11:0] OFS_HYST_B   = 12'h089;
    localparam logic [11:0] OFS_LINK     = 12'h300;
    localparam logic [11:0] OFS_LATENCY  = 12'h302;
    localparam logic [11:0] OFS_MF_DEL   = 12'h304;
    localparam logic [11:0] OFS_MF_VAR   = 12'h306;
    localparam logic [11:0] OFS_INVERT   = 12'h334;
    localparam logic [11:0] OFS_SCR      = 12'h453;
    localparam logic [11:0] OFS_SUBCLASS = 12'h458;
    // field positions
    localparam int SCR_BIT      = 7;
    localparam int LINK_EN_BIT  = 0;
    localparam int IRQ_BIT      = 0;
    localparam int SUBCLASS_LSB = 5;
    // widths and sizes
    localparam int DATA_W     = 32;
    localparam int LANE_W     = 3;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_W     = 35;
    localparam logic [4:0] FIFO_ROOM = 5'h0d;
    // processing clocks per multiframe
    localparam logic [7:0] MF_PCLKS = 8'h10;
    // reset values
    localparam logic [7:0] RST_SUBCLASS = 8'h20;
    localparam logic [7:0] RST_JWIN     = 8'h04;
    // codes
    localparam logic [2:0] SUBCLASS_0   = 3'h0;
    localparam logic [2:0] SUBCLASS_1   = 3'h1;
    localparam logic [1:0] MODE_MONITOR = 2'h0;
    localparam logic [1:0] MODE_CONT    = 2'h1;
    localparam logic [1:0] MODE_ONESHOT = 2'h2;
    // sync machine states
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_ARMED = 4'h2,
        ST_MON   = 4'h4,
        ST_CONT  = 4'h8
    } sync_state_e;
endpackage

// ===== tx_model.sv
`timescale 1ns/1ps
// lane transmitter: counted words, valid held until taken
module tx_model (
    input  wire logic                    clk_in,   // clock
    input  wire logic                    go_in,    // send enable
    input  wire logic                    ready_in, // device room
    output logic [align_pkg::DATA_W-1:0] data_out, // lane word
    output logic [align_pkg::LANE_W-1:0] lane_out, // lane number
    output logic                         valid_out // word valid
);
    import align_pkg::*;
    logic [7:0] k_q = 8'h00; // word counter
    // idle at time zero
    initial
    begin
        data_out  = 32'h0;
        lane_out  = 3'h0;
        valid_out = 1'b0;
    end
    // next word once taken; idle data toggles every cycle
    always @(posedge clk_in)
    begin
        if (!valid_out || ready_in)
        begin
            valid_out <= #1 go_in;
            lane_out  <= #1 {1'b0, k_q[1:0]};
            data_out  <= #1 go_in ? {k_q, ~k_q, k_q ^ 8'h5a, 8'hc3} : ~data_out;
            k_q       <= k_q + {7'h00, go_in};
        end
    end
endmodule

// ===== test_serdes_rx_lane_sync_descramble.sv
`timescale 1ns/1ps
// bench: register calls, sysref pulses, lane traffic
module test_serdes_rx_lane_sync_descramble;
    import align_pkg::*;
    logic        clk_in = 1'b0;        // clock
    logic        rst_b_in = 1'b0;      // reset
    logic [11:0] reg_addr_in = 12'h0;  // address
    logic        reg_wr_in = 1'b0;     // write strobe
    logic [7:0]  reg_wdata_in = 8'h0;  // write data
    logic        ilas_end_in = 1'b0;   // first data
    logic        sysref_in = 1'b0;     // sysref pin
    logic [1:0]  dac_phase_in = 2'h1;  // capture phase
    logic        data_ready_in = 1'b0; // sink ready
    logic        go = 1'b0;            // traffic on
    logic        descramble_enable = 1'b0;           // descramble expected
    logic [7:0]  inv_mask = 8'h04;     // inverted lanes
    logic [7:0]  reg_rdata_out;        // read data
    logic [31:0] lane_data_in, data_out;
    logic [2:0]  lane_id_in, data_lane_out;
    logic        lane_valid_in, lane_ready_out, data_valid_out, lmfc_rx_out, irq, link_en;
    logic [14:0] hist [8] = '{default: 15'h0}; // per-lane history
    logic [31:0] sent_q [$];           // accepted words
    logic [2:0]  lane_q [$];           // their lanes
    int          n_errors = 0;         // mismatches
    int          n_checks = 0;         // comparisons
    int          n_mf = 0;             // local mf pulses
    int          i;                    // loop count
    lane_align_top u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
        .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .lane_data_in(lane_data_in), .lane_id_in(lane_id_in), .lane_valid_in(lane_valid_in),
        .lane_ready_out(lane_ready_out), .ilas_end_in(ilas_end_in), .sysref_in(sysref_in),
        .dac_phase_in(dac_phase_in), .data_out(data_out), .data_lane_out(data_lane_out),
        .data_valid_out(data_valid_out), .data_ready_in(data_ready_in), .lmfc_rx_out(lmfc_rx_out),
        .edge_tolerance_irq_out(irq), .link_enable_out(link_en));
    tx_model u_tx (.clk_in(clk_in), .go_in(go), .ready_in(lane_ready_out),
        .data_out(lane_data_in), .lane_out(lane_id_in), .valid_out(lane_valid_in));
    // 4 ns clock
    always #2 clk_in = ~clk_in;
    // compare, count, report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one register write, then an idle edge so strobes never touch
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        @(posedge clk_in);
        #1;
        reg_wr_in = 1'b0;
        @(posedge clk_in);
        #1;
    endtask
    // read one edge after address, compare
    task automatic rdc(input logic [11:0] a, input logic [7:0] e);
        reg_addr_in = a;
        @(posedge clk_in);
        #1;
        chk(reg_rdata_out, e);
    endtask
    // sysref pulse, next pulse gap cycles later
    task automatic sref(input int gap);
        sysref_in = 1'b1;
        repeat (4) @(posedge clk_in);
        #1;
        sysref_in = 1'b0;
        repeat (gap - 4) @(posedge clk_in);
        #1;
    endtask
    // empty the buffer with a stalling sink
    task automatic drain;
        for (i = 0; i < 400 && sent_q.size() > 0; i++)
        begin
            data_ready_in = ~data_ready_in;
            @(posedge clk_in);
            #1;
        end
        chk(sent_q.size(), 32'h0);
        if (i == 400)
            test_done();
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // invert, then 1+x^14+x^15 over the msb-first stream
    function automatic logic [31:0] exp_w(input logic [31:0] w, input logic [2:0] l);
        logic [46:0] s;
        logic [31:0] o;
        s = {hist[l], w ^ {32{inv_mask[l]}}};
        o = s[31:0];
        if (descramble_enable)
            for (int j = 0; j < 32; j++)
                o[j] = s[j] ^ s[j + 14] ^ s[j + 15];
        hist[l] = s[14:0];
        return o;
    endfunction
    // record accepted words, check popped ones
    always @(posedge clk_in)
    begin
        if (lane_valid_in && lane_ready_out)
        begin
            sent_q.push_back(lane_data_in);
            lane_q.push_back(lane_id_in);
        end
        if (data_valid_out && data_ready_in && sent_q.size() > 0)
        begin
            chk(data_lane_out, lane_q[0]);
            chk(data_out, exp_w(sent_q.pop_front(), lane_q.pop_front()));
        end
    end
    initial
    begin
        repeat (12) @(posedge clk_in);
        #1;
        chk(lane_ready_out, 1'b0);
        rst_b_in = 1'b1;
        rdc(OFS_SUBCLASS, RST_SUBCLASS);
        rdc(OFS_JWIN, RST_JWIN);
        wr(OFS_LATENCY, 8'h5a);
        rdc(OFS_LATENCY, 8'h00);
        rdc(12'h100, 8'h00);
        $display("test registers done");
        sref(16);
        wr(OFS_PULSES, 8'h00);
        repeat (3) sref(16);
        wr(OFS_STAT_LO, 8'h00);
        rdc(OFS_PULSES, 8'h03);
        wr(OFS_MODE, 8'h00);
        wr(OFS_MODE, 8'h02);
        sref(14);
        wr(OFS_IRQ, 8'h01);
        sref(19);
        chk(irq, 1'b0);
        sref(16);
        sref(8);
        wr(OFS_STAT_LO, 8'h00);
        rdc(OFS_STAT_LO, 8'h0c);
        rdc(OFS_STAT_HI, 8'h00);
        rdc(OFS_PHASE_LO, 8'h3f);
        rdc(OFS_PHASE_HI, 8'h00);
        chk(irq, 1'b1);
        $display("test one-shot done");
        wr(OFS_MODE, 8'h01);
        sref(15);
        wr(OFS_JWIN, 8'h0f);
        wr(OFS_IRQ, 8'h01);
        chk(irq, 1'b0);
        sref(16);
        sref(8);
        wr(OFS_STAT_LO, 8'h00);
        rdc(OFS_STAT_LO, 8'h00);
        chk(irq, 1'b0);
        $display("test continuous done");
        wr(OFS_MODE, 8'h00);
        wr(OFS_SUBCLASS, 8'h00);
        repeat (20) @(posedge clk_in);
        #1;
        wr(OFS_STAT_LO, 8'h00);
        rdc(OFS_STAT_LO, 8'h20);
        wr(OFS_MODE, 8'h01);
        for (i = 0; i < 40; i++)
        begin
            @(posedge clk_in);
            #1;
            n_mf += lmfc_rx_out;
        end
        chk(n_mf, 32'h2);
        wr(OFS_STAT_LO, 8'h00);
        rdc(OFS_STAT_LO, 8'h00);
        $display("test subclass zero done");
        wr(OFS_INVERT, inv_mask);
        wr(OFS_LINK, 8'h01);
        chk(link_en, 1'b1);
        go = 1'b1;
        for (i = 0; i < 60 && lane_ready_out; i++)
        begin
            @(posedge clk_in);
            #1;
        end
        chk(lane_ready_out, 1'b0);
        if (i == 60)
            test_done();
        go = 1'b0;
        ilas_end_in = 1'b1;
        @(posedge clk_in);
        #1;
        ilas_end_in = 1'b0;
        rdc(OFS_LATENCY, 8'h0d);
        drain();
        chk(lane_ready_out, 1'b1);
        $display("test lanes done");
        descramble_enable = 1'b1;
        wr(OFS_SCR, 8'h80);
        rdc(OFS_SCR, 8'h80);
        go = 1'b1;
        repeat (24) @(posedge clk_in);
        #1;
        go = 1'b0;
        drain();
        $display("test descramble done");
        test_done();
    end
endmodule
